// [design/mpc_pkg.sv]
// package for the multi-purpose compare block: register map, field layout, codes
// assumes one 50 MHz clock and a plain strobe register port
package mpc_pkg;
  localparam int MPC_AW = 4;
  localparam int MPC_DW = 32;
  localparam int MPC_NREG = 4;
  // register indices on the plain port
  localparam logic [3:0] MPC_OFF_MODE_ONE = 4'h0;
  localparam logic [3:0] MPC_OFF_STATUS_ONE = 4'h1;
  localparam logic [3:0] MPC_OFF_CAUSE_CLEAR = 4'h2;
  localparam logic [3:0] MPC_OFF_CMP_STATUS = 4'h3;
  localparam logic [3:0] MPC_OFF_CMP_MODE = 4'h4;
  localparam logic [3:0] MPC_OFF_ACT_CODES = 4'h5;
  localparam logic [3:0] MPC_OFF_CMP_REG0 = 4'h8;
  localparam logic [1:0] MPC_CMP_SEL_MSB = 2'h3;
  // per-register mode nibble: condition in [3:2], object in [1:0]
  localparam int MPC_MODE_W = 4;
  localparam int MPC_COND_LSB = 2;
  localparam logic [1:0] MPC_COND_GE = 2'h0;
  localparam logic [1:0] MPC_COND_GT = 2'h1;
  localparam logic [1:0] MPC_COND_EQ = 2'h2;
  localparam logic [1:0] MPC_COND_LT = 2'h3;
  localparam logic [1:0] MPC_OBJ_LOGICAL = 2'h0;
  localparam logic [1:0] MPC_OBJ_REAL = 2'h1;
  localparam logic [1:0] MPC_OBJ_SPEED = 2'h2;
  localparam logic [1:0] MPC_OBJ_TIMER = 2'h3;
  // action codes, one byte per set in the action code register
  localparam int MPC_ACT_W = 8;
  localparam logic [7:0] MPC_ACT_LD_SPEED = 8'h01;
  localparam logic [7:0] MPC_ACT_LD_PULSE = 8'h02;
  localparam logic [7:0] MPC_ACT_LD_SPLIT = 8'h03;
  localparam logic [7:0] MPC_ACT_LD_BYSET = 8'h04;
  localparam logic [7:0] MPC_ACT_SV_LOGICAL = 8'h05;
  localparam logic [7:0] MPC_ACT_SV_REAL = 8'h06;
  localparam logic [7:0] MPC_ACT_SV_TIMER = 8'h07;
  localparam logic [7:0] MPC_ACT_SV_BYSET = 8'h08;
  localparam logic [7:0] MPC_ACT_LD_REL = 8'h0F;
  localparam logic [7:0] MPC_ACT_LD_ABS = 8'h10;
  // reset values
  localparam logic [3:0] MPC_RST_NIB = 4'h0;
  localparam logic [15:0] MPC_RST_MODE = 16'h0000;
  localparam logic [31:0] MPC_RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    MPC_LD_DRIVE_SPEED,
    MPC_LD_PULSE_OR_FINISH,
    MPC_LD_SPLIT_PULSE_ONE,
    MPC_LD_LOGICAL_POSITION,
    MPC_LD_REAL_POSITION,
    MPC_LD_INITIAL_SPEED,
    MPC_LD_ACCELERATION
  } mpc_load_kind_t;

  // live motion values that the compare registers look at or save
  typedef struct packed {
    logic signed [31:0] logical_position;
    logic signed [31:0] real_position;
    logic signed [31:0] current_speed;
    logic signed [31:0] current_timer;
    logic signed [31:0] current_accel_decel;
  } mpc_motion_t;

  // parameter load towards the drive generator
  typedef struct packed {
    logic valid;
    mpc_load_kind_t kind;
    logic start_relative;
    logic start_absolute;
    logic [31:0] value;
  } mpc_load_t;

  typedef struct packed {
    logic [MPC_AW-1:0] addr;
    logic [MPC_DW-1:0] wdata;
    logic wr;
    logic rd;
  } mpc_bus_t;
endpackage

// [design/mpc_compare_events.sv]
// multi-purpose compare registers: live compare status, edge interrupts, sync load/save
// assumes inputs synchronous to i_clk and sync activation pulses from an outside trigger engine
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module mpc_compare_events (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire mpc_pkg::mpc_bus_t i_bus,
  output logic [mpc_pkg::MPC_DW-1:0] o_rdata,
  input wire mpc_pkg::mpc_motion_t i_motion,
  input wire logic [mpc_pkg::MPC_NREG-1:0] i_sync_fire,
  output mpc_pkg::mpc_load_t o_load,
  output logic o_irq
);
  import mpc_pkg::*;

  typedef struct packed {
    logic [MPC_NREG-1:0] irq_en;
    logic [MPC_NREG-1:0] cause;
    logic [MPC_NREG-1:0] prev_meet;
    logic [15:0] cmp_mode;
    logic [MPC_NREG-1:0][MPC_ACT_W-1:0] act_code;
    logic [MPC_NREG-1:0][31:0] cmp;
    logic [MPC_DW-1:0] rdata;
    logic irq;
    mpc_load_t load;
  } mpc_state_t;

  mpc_state_t st;
  mpc_state_t next_st;
  logic [MPC_NREG-1:0] meet;
  logic [MPC_NREG-1:0] eq;
  logic [MPC_NREG-1:0] ge;
  logic [MPC_NREG-1:0] edge_evt;
  logic [15:0] cmp_status;

  // live comparison of each compare register against its selected object
  genvar g;
  generate
    for (g = 0; g < MPC_NREG; g++) begin : g_cmp
      logic [1:0] obj;
      logic [1:0] cond;
      logic signed [31:0] val;
      assign obj = st.cmp_mode[g*MPC_MODE_W +: 2];
      assign cond = st.cmp_mode[g*MPC_MODE_W+MPC_COND_LSB +: 2];
      assign val = (obj == MPC_OBJ_LOGICAL) ? i_motion.logical_position :
                   (obj == MPC_OBJ_REAL) ? i_motion.real_position :
                   (obj == MPC_OBJ_SPEED) ? i_motion.current_speed : i_motion.current_timer;
      assign eq[g] = (val == $signed(st.cmp[g]));
      assign ge[g] = (val >= $signed(st.cmp[g]));
      // condition decides only the event, never the status bits
      assign meet[g] = (cond == MPC_COND_GE) ? ge[g] :
                       (cond == MPC_COND_GT) ? (ge[g] && !eq[g]) :
                       (cond == MPC_COND_EQ) ? eq[g] : !ge[g];
      assign cmp_status[2*g+1] = eq[g];
      assign cmp_status[2*g] = ge[g];
    end
  endgenerate

  // upper half of the compare status word has no register behind it
  assign cmp_status[15:2*MPC_NREG] = '0;

  // rising condition only; prev_meet runs even while disabled so enabling never fires on a level
  assign edge_evt = meet & ~st.prev_meet & st.irq_en;

  // next state: register port, events, sync load/save
  always_comb begin
    logic [MPC_NREG-1:0] clr;
    logic found;
    logic [1:0] sel;
    logic [7:0] code;
    next_st = st;
    clr = '0;
    found = 1'b0;
    sel = 2'h0;
    code = 8'h00;
    next_st.prev_meet = meet;
    next_st.rdata = '0;
    next_st.load.valid = 1'b0;
    next_st.load.start_relative = 1'b0;
    next_st.load.start_absolute = 1'b0;
    // host writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        MPC_OFF_MODE_ONE: next_st.irq_en = i_bus.wdata[MPC_NREG-1:0];
        MPC_OFF_CAUSE_CLEAR: clr = i_bus.wdata[MPC_NREG-1:0];
        MPC_OFF_CMP_MODE: next_st.cmp_mode = i_bus.wdata[15:0];
        MPC_OFF_ACT_CODES: next_st.act_code = i_bus.wdata;
        default: begin
          if (i_bus.addr[MPC_AW-1:2] == MPC_OFF_CMP_REG0[MPC_AW-1:2]) begin
            next_st.cmp[i_bus.addr[1:0]] = i_bus.wdata;
          end
        end
      endcase
    end
    // host reads; data stand one cycle, unmapped reads give zero
    if (i_bus.rd) begin
      case (i_bus.addr)
        MPC_OFF_MODE_ONE: next_st.rdata = {28'h0000000, st.irq_en};
        MPC_OFF_STATUS_ONE: begin
          next_st.rdata = {28'h0000000, st.cause};
          clr = st.cause;
        end
        MPC_OFF_CMP_STATUS: next_st.rdata = {16'h0000, cmp_status};
        MPC_OFF_CMP_MODE: next_st.rdata = {16'h0000, st.cmp_mode};
        MPC_OFF_ACT_CODES: next_st.rdata = st.act_code;
        default: begin
          if (i_bus.addr[MPC_AW-1:2] == MPC_OFF_CMP_REG0[MPC_AW-1:2]) begin
            next_st.rdata = st.cmp[i_bus.addr[1:0]];
          end
        end
      endcase
    end
    // an event in the clearing cycle survives: set wins over clear
    next_st.cause = (st.cause & ~clr) | edge_evt;
    // lowest active set wins; one load/save per cycle keeps the drive port single
    for (int i = MPC_NREG - 1; i >= 0; i--) begin
      if (i_sync_fire[i]) begin
        found = 1'b1;
        sel = i[1:0];
      end
    end
    if (found) begin
      code = st.act_code[sel];
      next_st.load.value = st.cmp[sel];
      case (code)
        MPC_ACT_LD_SPEED: begin
          next_st.load.valid = 1'b1;
          next_st.load.kind = MPC_LD_DRIVE_SPEED;
        end
        MPC_ACT_LD_PULSE: begin
          next_st.load.valid = 1'b1;
          next_st.load.kind = MPC_LD_PULSE_OR_FINISH;
        end
        MPC_ACT_LD_SPLIT: begin
          next_st.load.valid = 1'b1;
          next_st.load.kind = MPC_LD_SPLIT_PULSE_ONE;
        end
        MPC_ACT_LD_BYSET: begin
          next_st.load.valid = 1'b1;
          case (sel)
            2'h0: next_st.load.kind = MPC_LD_LOGICAL_POSITION;
            2'h1: next_st.load.kind = MPC_LD_REAL_POSITION;
            2'h2: next_st.load.kind = MPC_LD_INITIAL_SPEED;
            default: next_st.load.kind = MPC_LD_ACCELERATION;
          endcase
        end
        MPC_ACT_LD_REL: begin
          next_st.load.valid = 1'b1;
          next_st.load.kind = MPC_LD_PULSE_OR_FINISH;
          next_st.load.start_relative = 1'b1;
        end
        MPC_ACT_LD_ABS: begin
          next_st.load.valid = 1'b1;
          next_st.load.kind = MPC_LD_PULSE_OR_FINISH;
          next_st.load.start_absolute = 1'b1;
        end
        // saves override a host write to the same register in that cycle
        MPC_ACT_SV_LOGICAL: next_st.cmp[sel] = i_motion.logical_position;
        MPC_ACT_SV_REAL: next_st.cmp[sel] = i_motion.real_position;
        MPC_ACT_SV_TIMER: next_st.cmp[sel] = i_motion.current_timer;
        MPC_ACT_SV_BYSET: begin
          if (sel == 2'h0) begin
            next_st.cmp[sel] = i_motion.current_speed;
          end else if (sel == 2'h1) begin
            next_st.cmp[sel] = i_motion.current_accel_decel;
          end
        end
        default: next_st.load.valid = 1'b0;
      endcase
    end
    next_st.irq = |(next_st.cause & next_st.irq_en);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st.irq_en <= MPC_RST_NIB;
      st.cause <= MPC_RST_NIB;
      st.prev_meet <= MPC_RST_NIB;
      st.cmp_mode <= MPC_RST_MODE;
      st.act_code <= MPC_RST_WORD;
      st.cmp <= '0;
      st.rdata <= MPC_RST_WORD;
      st.irq <= 1'b0;
      st.load <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_load = st.load;
  assign o_irq = st.irq;

  // checks
  sequence s_fire0(logic [7:0] c);
    i_sync_fire[0] && (st.act_code[0] == c);
  endsequence

  property p_edge_sets;
    @(posedge i_clk) disable iff (!i_reset_n)
    (|edge_evt) |=> ((st.cause & $past(edge_evt)) == $past(edge_evt));
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("rising condition did not set cause");

  property p_no_level;
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> ((st.cause & ~$past(st.cause) & ~($past(meet) & ~$past(st.prev_meet))) == 4'h0);
  endproperty
  a_no_level: assert property (p_no_level) else $error("cause set without a false to true edge");

  property p_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
    !(i_bus.rd && i_bus.addr == MPC_OFF_STATUS_ONE) && !(i_bus.wr && i_bus.addr == MPC_OFF_CAUSE_CLEAR)
      |=> ((st.cause & $past(st.cause)) == $past(st.cause));
  endproperty
  a_hold: assert property (p_hold) else $error("cause bit dropped without a clear");

  property p_read_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.rd && i_bus.addr == MPC_OFF_STATUS_ONE && edge_evt == 4'h0)
      |=> (st.cause == 4'h0 && o_rdata[MPC_NREG-1:0] == $past(st.cause));
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear causes");

  property p_irq_level;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_irq == (|(st.cause & st.irq_en));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output disagrees with causes");

  property p_cmp_status;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.rd && i_bus.addr == MPC_OFF_CMP_STATUS) |=> (o_rdata == {16'h0000, $past(cmp_status)});
  endproperty
  a_cmp_status: assert property (p_cmp_status) else $error("compare status read is wrong");

  property p_ld_speed;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_LD_SPEED) |=> (o_load.valid && o_load.kind == MPC_LD_DRIVE_SPEED && o_load.value == $past(st.cmp[0]));
  endproperty
  a_ld_speed: assert property (p_ld_speed) else $error("drive speed load missing");

  property p_ld_byset;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_LD_BYSET) |=> (o_load.valid && o_load.kind == MPC_LD_LOGICAL_POSITION);
  endproperty
  a_ld_byset: assert property (p_ld_byset) else $error("set zero code 04h did not load position");

  property p_ld_rel;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_LD_REL) |=> (o_load.valid && o_load.start_relative && !o_load.start_absolute)
      ##1 (!o_load.start_relative || $past(i_sync_fire != 4'h0));
  endproperty
  a_ld_rel: assert property (p_ld_rel) else $error("relative start missing");

  property p_sv_logical;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_SV_LOGICAL) |=> (st.cmp[0] == $past(i_motion.logical_position));
  endproperty
  a_sv_logical: assert property (p_sv_logical) else $error("logical position not saved");

  property p_sv_speed;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_SV_BYSET) |=> (st.cmp[0] == $past(i_motion.current_speed));
  endproperty
  a_sv_speed: assert property (p_sv_speed) else $error("current speed not saved");

  // condition false for one edge, then true with the interrupt enabled
  sequence s_rise0;
    !meet[0] ##1 (meet[0] && st.irq_en[0]);
  endsequence

  property p_rise0;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_rise0 |=> st.cause[0];
  endproperty
  a_rise0: assert property (p_rise0) else $error("false to true step of compare zero left no cause");

  property p_masked;
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> ((st.cause & ~$past(st.cause) & ~$past(st.irq_en)) == 4'h0);
  endproperty
  a_masked: assert property (p_masked) else $error("cause set on a disabled compare");

  property p_clear_reg;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.wr && i_bus.addr == MPC_OFF_CAUSE_CLEAR)
      |=> ((st.cause & $past(i_bus.wdata[MPC_NREG-1:0]) & ~$past(edge_evt)) == 4'h0);
  endproperty
  a_clear_reg: assert property (p_clear_reg) else $error("clear register left a cause set");

  // equal can never stand without greater-or-equal
  property p_eq_ge;
    @(posedge i_clk) disable iff (!i_reset_n)
    ((cmp_status >> 1) & ~cmp_status & 16'h5555) == 16'h0000;
  endproperty
  a_eq_ge: assert property (p_eq_ge) else $error("equal bit set without greater-or-equal");

  property p_ld_pulse;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_LD_PULSE) |=> (o_load.valid && o_load.kind == MPC_LD_PULSE_OR_FINISH &&
      !o_load.start_relative && !o_load.start_absolute);
  endproperty
  a_ld_pulse: assert property (p_ld_pulse) else $error("pulse count load missing");

  property p_ld_abs;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_LD_ABS) |=> (o_load.valid && o_load.kind == MPC_LD_PULSE_OR_FINISH &&
      o_load.start_absolute && !o_load.start_relative && o_load.value == $past(st.cmp[0]));
  endproperty
  a_ld_abs: assert property (p_ld_abs) else $error("absolute start missing");

  property p_sv_timer;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_fire0(MPC_ACT_SV_TIMER) |=> (!o_load.valid && st.cmp[0] == $past(i_motion.current_timer));
  endproperty
  a_sv_timer: assert property (p_sv_timer) else $error("current timer not saved");

  // a load stands one cycle unless another set fires right behind it
  property p_load_pulse;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_load.valid && i_sync_fire == 4'h0) |=> !o_load.valid;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load valid stood longer than one cycle");

  property p_lowest_wins;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_sync_fire[1:0] == 2'h3 && st.act_code[0] == MPC_ACT_LD_SPEED)
      |=> (o_load.valid && o_load.kind == MPC_LD_DRIVE_SPEED && o_load.value == $past(st.cmp[0]));
  endproperty
  a_lowest_wins: assert property (p_lowest_wins) else $error("set zero did not win over set one");
endmodule // mpc_compare_events

// [verif/mpc_host_model.sv]
// host model: register writes and reads on the plain strobe port
// assumes each task is entered at a rising edge of i_clk
`timescale 1ns/1ns
module mpc_host_model (
  input wire logic i_clk,
  input wire logic [mpc_pkg::MPC_DW-1:0] i_rdata,
  output mpc_pkg::mpc_bus_t o_bus
);
  import mpc_pkg::*;
  initial o_bus = '0;
  // released lines show the inverse so a stale address never looks live
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    o_bus <= '{a, d, 1'h1, 1'h0};
    @(posedge i_clk);
    o_bus <= '{~a, ~d, 1'h0, 1'h0};
    @(posedge i_clk);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    o_bus <= '{a, 32'hFFFF_FFFF, 1'h0, 1'h1};
    @(posedge i_clk);
    o_bus <= '{~a, 32'h0, 1'h0, 1'h0};
    @(posedge i_clk);
    d = i_rdata; // taken at the edge that closes the data cycle
  endtask
endmodule // mpc_host_model

// [verif/tb_mpc_compare_events.sv]
// testbench: live compare status, compare events, sync load and save
// assumes the host model owns the register port; the bench drives motion and sync pulses
`timescale 1ns/1ns
module tb_mpc_compare_events;
  import mpc_pkg::*;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  mpc_bus_t bus;
  logic [31:0] rdata;
  mpc_motion_t motion = '0;
  logic [3:0] fire = 4'h0;
  mpc_load_t load;
  logic irq;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] d;
  logic signed [31:0] creg [4] = '{default: 32'h0};

  always #10 i_clk = ~i_clk;

  mpc_compare_events mpc_compare_events_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
    .i_motion(motion), .i_sync_fire(fire), .o_load(load), .o_irq(irq));
  mpc_host_model mpc_host_model_i (.i_clk(i_clk), .i_rdata(rdata), .o_bus(bus));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard: the run needs well under two thousand cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    mpc_host_model_i.rd(a, d);
    check(d, exp);
  endtask

  // compare register writes are mirrored so expectations never come from the design
  task automatic wcmp(input int n, input logic [31:0] v);
    mpc_host_model_i.wr(MPC_OFF_CMP_REG0 + 4'(n), v);
    creg[n] = v;
  endtask

  // reg1 looks at real position, the others at logical position
  function automatic logic [31:0] st_exp();
    logic signed [31:0] o;
    st_exp = '0;
    for (int k = 0; k < 4; k++) begin
      o = (k == 1) ? motion.real_position : motion.logical_position;
      st_exp[2*k+:2] = {o == creg[k], o >= creg[k]};
    end
  endfunction

  task automatic t_reset();
    check({31'h0, irq}, 32'h0);
    rdc(MPC_OFF_MODE_ONE, 32'h0);
    rdc(MPC_OFF_STATUS_ONE, 32'h0);
    rdc(MPC_OFF_CMP_STATUS, 32'hFF);
    rdc(MPC_OFF_CMP_MODE, 32'h0);
    rdc(4'h6, 32'h0);
    $display("test reset done");
  endtask

  // status ignores the condition: reg0 is set to equality yet shows both bits
  task automatic t_status();
    int v [3] = '{-5, 100, 150};
    wcmp(0, 32'd100);
    wcmp(1, 32'd7);
    mpc_host_model_i.wr(MPC_OFF_CMP_MODE, 32'h0018);
    rdc(MPC_OFF_CMP_MODE, 32'h0018);
    motion.real_position <= 32'sd7;
    for (int i = 0; i < 3; i++) begin
      motion.logical_position <= v[i];
      cyc(2);
      rdc(MPC_OFF_CMP_STATUS, st_exp());
    end
    $display("test status done");
  endtask

  task automatic t_irq();
    mpc_host_model_i.wr(MPC_OFF_CMP_MODE, 32'h9000);
    wcmp(3, 32'd30000);
    motion.logical_position <= 32'sd150;
    cyc(3);
    mpc_host_model_i.wr(MPC_OFF_MODE_ONE, 32'h1);
    cyc(3);
    check({31'h0, irq}, 32'h0);
    rdc(MPC_OFF_STATUS_ONE, 32'h0);
    motion.logical_position <= 32'sd50;
    cyc(3);
    motion.logical_position <= 32'sd150;
    cyc(4);
    check({31'h0, irq}, 32'h1);
    rdc(MPC_OFF_STATUS_ONE, 32'h1);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    rdc(MPC_OFF_STATUS_ONE, 32'h0);
    // reg0 masked now: its rising edge must leave no cause behind
    mpc_host_model_i.wr(MPC_OFF_MODE_ONE, 32'h8);
    motion.logical_position <= 32'sd50;
    motion.real_position <= 32'sd29999;
    cyc(3);
    motion.logical_position <= 32'sd150;
    motion.real_position <= 32'sd30000;
    cyc(4);
    check({31'h0, irq}, 32'h1);
    rdc(MPC_OFF_STATUS_ONE, 32'h8);
    mpc_host_model_i.wr(MPC_OFF_MODE_ONE, 32'h0);
    $display("test interrupt done");
  endtask

  // every load and save code on every set, plus one unknown code
  task automatic t_sync();
    logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0F, 8'h10, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
    logic [7:0] c;
    logic [31:0] e;
    mpc_load_kind_t k;
    motion <= '{32'h11, 32'h22, 32'h44, 32'h33, 32'h55};
    for (int n = 0; n < 4; n++) begin
      wcmp(n, 32'h1000 + n);
    end
    for (int i = 0; i < 11; i++) begin
      for (int n = 0; n < 4; n++) begin
        c = codes[i];
        mpc_host_model_i.wr(MPC_OFF_ACT_CODES, {4{c}});
        fire[n] <= 1'h1;
        @(posedge i_clk);
        fire <= 4'h0;
        #1;
        // code 04h kinds follow the set number in the enum order
        k = (c == 8'h01) ? MPC_LD_DRIVE_SPEED : (c == 8'h03) ? MPC_LD_SPLIT_PULSE_ONE :
            (c == 8'h04) ? mpc_load_kind_t'(3 + n) : MPC_LD_PULSE_OR_FINISH;
        if (c inside {[8'h05:8'h09]}) begin
          check({31'h0, load.valid}, 32'h0);
          @(posedge i_clk);
          e = (c == 8'h05) ? 32'h11 : (c == 8'h06) ? 32'h22 : (c == 8'h07) ? 32'h33 : creg[n];
          e = (c == 8'h08 && n == 0) ? 32'h44 : (c == 8'h08 && n == 1) ? 32'h55 : e;
          rdc(MPC_OFF_CMP_REG0 + 4'(n), e);
          creg[n] = e;
        end else begin
          check({load.valid, load.start_relative, load.start_absolute, 26'h0, load.kind},
                {1'h1, c == 8'h0F, c == 8'h10, 26'h0, k});
          check(load.value, creg[n]);
          @(posedge i_clk);
        end
      end
    end
    $display("test sync done");
  endtask

  // strict conditions on speed and timer, the clear register, two sets fired at once
  task automatic t_cond();
    wcmp(0, 32'd100);
    wcmp(1, 32'd50);
    mpc_host_model_i.wr(MPC_OFF_CMP_MODE, 32'h00F6);
    motion.current_speed <= 32'sd100;
    motion.current_timer <= 32'sd50;
    cyc(2);
    rdc(MPC_OFF_CMP_STATUS, 32'h0F);
    mpc_host_model_i.wr(MPC_OFF_MODE_ONE, 32'h3);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    motion.current_speed <= 32'sd101;
    motion.current_timer <= 32'sd49;
    cyc(3);
    check({31'h0, irq}, 32'h1);
    mpc_host_model_i.wr(MPC_OFF_CAUSE_CLEAR, 32'h1);
    check({31'h0, irq}, 32'h1);
    rdc(MPC_OFF_STATUS_ONE, 32'h2);
    check({31'h0, irq}, 32'h0);
    mpc_host_model_i.wr(MPC_OFF_MODE_ONE, 32'h0);
    mpc_host_model_i.wr(MPC_OFF_ACT_CODES, 32'h0000_0201);
    rdc(MPC_OFF_ACT_CODES, 32'h0000_0201);
    fire <= 4'h3;
    @(posedge i_clk);
    fire <= 4'h0;
    #1;
    check({load.valid, load.start_relative, load.start_absolute, 26'h0, load.kind},
          {1'h1, 2'h0, 26'h0, MPC_LD_DRIVE_SPEED});
    check(load.value, creg[0]);
    @(posedge i_clk);
    $display("test condition done");
  endtask

  initial begin
    cyc(20);
    i_reset_n <= 1'h1;
    @(posedge i_clk);
    t_reset();
    t_status();
    t_irq();
    t_sync();
    t_cond();
    close_out();
  end
endmodule // tb_mpc_compare_events
